//--- verilog/adcr_pkg.sv
/*
 * Shared constants for the conversion-result read-out port: pin sync
 * positions, widths, oversampling codes, conversion timing and states.
 * Assumes a single 125 MHz system clock inside the device.
 */
package adcr_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int NUM_CH = 8;
    localparam int CH_W = 16;
    localparam int BYTE_W = 8;
    localparam int CH_IDX_W = 3;
    localparam int OS_W = 3;
    localparam int ACC_W = 22;
    localparam int BYTE_IDX_W = 4;
    localparam int SER_POS_W = 7;
    localparam int CNT_W = 16;

    // ------------------------------------------------------------
    // positions in the synchronised pin vector
    // ------------------------------------------------------------
    localparam int PIN_W = 11;
    localparam int PIN_CS_N = 0;
    localparam int PIN_RD_N = 1;
    localparam int PIN_SCLK = 2;
    localparam int PIN_CSTA = 3;
    localparam int PIN_CSTB = 4;
    localparam int PIN_ISEL = 5;
    localparam int PIN_BSEL = 6;
    localparam int PIN_HBF = 7;
    localparam int PIN_OS_LO = 8;

    // ------------------------------------------------------------
    // oversampling and timing
    // ------------------------------------------------------------
    localparam logic [OS_W-1:0] OS_MAX_SHIFT = 3'h6;
    localparam logic [OS_W-1:0] OS_RESET = 3'h0;
    localparam logic [3:0] BIT_LAST = 4'hF;
    localparam int CONV_TIME_NS = 4000;
    localparam int CLK_PERIOD_NS = 8;
    // longest time per pass, rounded down
    localparam int PASS_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;

    typedef enum logic {
        ST_IDLE,
        ST_CONV
    } adcr_state_t;
endpackage : adcr_pkg

//--- verilog/adcr_readout.sv
/*
 * Read-out logic of an eight-channel 16-bit simultaneous-sampling converter:
 * conversion busy timing with oversampling average, byte-wide and serial
 * result read-out paced by host strobes.
 * Assumes host pins are asynchronous and much slower than i_clk, and that
 * the converter core delivers raw samples on i_raw_* in the i_clk domain.
 */
`timescale 1ns/1ps

// Summary of operation
// - interface select high and byte select high choose byte-wide read-out
// - byte mode sends every 16-bit result as two 8-bit transfers
// - high_byte_first high sends the upper byte first, low the lower first
// - select fall enables the byte lane; each read fall gives next byte
// - byte mode flag rises on first read fall, drops on the third
// - interface select high with byte select low chooses serial read-out
// - select high in serial mode floats outputs and ignores serial clock
// - select fall shows the MSB; rising clocks shift out the other 15 bits
// - sixteen clocks per channel, ascending; framing per frame or channel
// - line A carries channels 1-4 then 5-8, line B 5-8 then 1-4
// - serial flag high from select fall with channel 1 until 16th fall
// - flag also marks channel 5 shifted out on line B
// - reads while busy return the previous conversion results
// - oversampling select is captured when busy falls, used next time
// - busy lasts longer as the oversampling ratio grows
// - with oversampling active results pass an averaging filter
// - busy fall loads all eight results into the output registers
// - after both start rising edges busy rises and holds for conversion
module adcr_readout #(
    parameter int P_PASS_CYCLES = adcr_pkg::PASS_CYCLES
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // host control pins
    input wire logic i_cs_n,
    input wire logic i_rd_n,
    input wire logic i_sclk,
    input wire logic i_convert_start_a,
    input wire logic i_convert_start_b,
    input wire logic i_interface_select,
    input wire logic i_byte_select,
    input wire logic i_high_byte_first,
    input wire logic [adcr_pkg::OS_W-1:0] i_oversampling_ratio_select,
    // raw samples from the converter core
    input wire logic i_raw_valid,
    input wire logic [adcr_pkg::CH_IDX_W-1:0] i_raw_chan,
    input wire logic [adcr_pkg::CH_W-1:0] i_raw_data,
    // core pacing
    output logic o_pass_start,
    // host status pins
    output logic o_busy,
    output logic o_first_channel_flag,
    output logic o_first_channel_flag_oe_n,
    // byte lane
    output logic [adcr_pkg::BYTE_W-1:0] o_byte_lane,
    output logic o_byte_lane_oe_n,
    // serial lines
    output logic o_serial_out_a,
    output logic o_serial_out_b,
    output logic o_serial_oe_n
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [adcr_pkg::PIN_W-1:0] pin_raw;
    logic [adcr_pkg::PIN_W-1:0] sync1_ff;
    logic [adcr_pkg::PIN_W-1:0] sync2_ff;
    logic [adcr_pkg::PIN_W-1:0] prev_ff;

    assign pin_raw = {i_oversampling_ratio_select, i_high_byte_first, i_byte_select,
                      i_interface_select, i_convert_start_b, i_convert_start_a,
                      i_sclk, i_rd_n, i_cs_n};

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1_ff <= 11'h7;
            sync2_ff <= 11'h7;
            prev_ff <= 11'h7;
        end else begin
            sync1_ff <= pin_raw;
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff;
        end
    end

    logic cs_low;
    logic cs_fall;
    logic rd_fall;
    logic sclk_rise;
    logic sclk_fall;
    logic csta_rise;
    logic cstb_rise;
    logic byte_mode;
    logic ser_mode;
    logic hbf;
    logic [adcr_pkg::OS_W-1:0] os_sync;

    assign cs_low = !sync2_ff[adcr_pkg::PIN_CS_N];
    assign cs_fall = cs_low && prev_ff[adcr_pkg::PIN_CS_N];
    // strobes only count while selected
    assign rd_fall = cs_low && prev_ff[adcr_pkg::PIN_RD_N]
                     && !sync2_ff[adcr_pkg::PIN_RD_N];
    assign sclk_rise = cs_low && !prev_ff[adcr_pkg::PIN_SCLK]
                       && sync2_ff[adcr_pkg::PIN_SCLK];
    assign sclk_fall = cs_low && prev_ff[adcr_pkg::PIN_SCLK]
                       && !sync2_ff[adcr_pkg::PIN_SCLK];
    assign csta_rise = sync2_ff[adcr_pkg::PIN_CSTA] && !prev_ff[adcr_pkg::PIN_CSTA];
    assign cstb_rise = sync2_ff[adcr_pkg::PIN_CSTB] && !prev_ff[adcr_pkg::PIN_CSTB];
    assign byte_mode = sync2_ff[adcr_pkg::PIN_ISEL] && sync2_ff[adcr_pkg::PIN_BSEL];
    assign ser_mode = sync2_ff[adcr_pkg::PIN_ISEL] && !sync2_ff[adcr_pkg::PIN_BSEL];
    assign hbf = sync2_ff[adcr_pkg::PIN_HBF];
    assign os_sync = sync2_ff[adcr_pkg::PIN_OS_LO +: adcr_pkg::OS_W];

    // ------------------------------------------------------------
    // conversion timing
    // ------------------------------------------------------------
    adcr_pkg::adcr_state_t state_ff;
    logic arm_a_ff;
    logic arm_b_ff;
    logic [adcr_pkg::OS_W-1:0] shift_ff;
    logic [adcr_pkg::CNT_W-1:0] cnt_ff;
    logic [adcr_pkg::CNT_W-1:0] pass_left_ff;
    logic start;
    logic end_conv;
    logic pass_done;

    // both starts must have risen; with oversampling the host ties them
    assign start = (state_ff == adcr_pkg::ST_IDLE) && (arm_a_ff || csta_rise)
                   && (arm_b_ff || cstb_rise);
    assign pass_done = (state_ff == adcr_pkg::ST_CONV) && (cnt_ff == '0);
    assign end_conv = pass_done && (pass_left_ff == '0);
    assign o_busy = (state_ff == adcr_pkg::ST_CONV);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            arm_a_ff <= 1'b0;
            arm_b_ff <= 1'b0;
        end else if (start) begin
            arm_a_ff <= 1'b0;
            arm_b_ff <= 1'b0;
        end else if (state_ff == adcr_pkg::ST_IDLE) begin
            arm_a_ff <= arm_a_ff || csta_rise;
            arm_b_ff <= arm_b_ff || cstb_rise;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_ff <= adcr_pkg::ST_IDLE;
            cnt_ff <= '0;
            pass_left_ff <= '0;
        end else begin
            case (state_ff)
                adcr_pkg::ST_IDLE: begin
                    if (start) begin
                        state_ff <= adcr_pkg::ST_CONV;
                        cnt_ff <= adcr_pkg::CNT_W'(P_PASS_CYCLES - 1);
                        // one pass per oversample: busy grows with ratio
                        pass_left_ff <= (16'h1 << shift_ff) - 16'h1;
                    end
                end
                default: begin
                    if (end_conv) begin
                        state_ff <= adcr_pkg::ST_IDLE;
                    end else if (pass_done) begin
                        cnt_ff <= adcr_pkg::CNT_W'(P_PASS_CYCLES - 1);
                        pass_left_ff <= pass_left_ff - 16'h1;
                    end else begin
                        cnt_ff <= cnt_ff - 16'h1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pass_start <= 1'b0;
        end else begin
            o_pass_start <= start || (pass_done && !end_conv);
        end
    end

    // ratio for the next conversion; reserved code means no averaging
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            shift_ff <= adcr_pkg::OS_RESET;
        end else if (end_conv) begin
            shift_ff <= (os_sync > adcr_pkg::OS_MAX_SHIFT) ? adcr_pkg::OS_RESET
                                                           : os_sync;
        end
    end

    // ------------------------------------------------------------
    // averaging filter and output data registers
    // ------------------------------------------------------------
    logic [adcr_pkg::CH_W-1:0] res_ff [adcr_pkg::NUM_CH];

    for (genvar g = 0; g < adcr_pkg::NUM_CH; g++) begin : g_ch
        logic signed [adcr_pkg::ACC_W-1:0] acc_ff;
        logic signed [adcr_pkg::ACC_W-1:0] avg;

        assign avg = acc_ff >>> shift_ff;

        always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                acc_ff <= '0;
            end else if (start) begin
                acc_ff <= '0;
            end else if (o_busy && i_raw_valid && i_raw_chan == g) begin
                acc_ff <= acc_ff + adcr_pkg::ACC_W'($signed(i_raw_data));
            end
        end

        // only busy fall updates: reads during busy see the previous set
        always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                res_ff[g] <= '0;
            end else if (end_conv) begin
                res_ff[g] <= avg[adcr_pkg::CH_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // byte-wide read-out
    // ------------------------------------------------------------
    logic [adcr_pkg::BYTE_IDX_W-1:0] byte_idx_ff;
    logic [adcr_pkg::CH_W-1:0] byte_word;
    logic msb_sel;

    assign byte_word = res_ff[byte_idx_ff[adcr_pkg::BYTE_IDX_W-1:1]];
    assign msb_sel = byte_idx_ff[0] ^ hbf;

    // a read racing busy fall loses to the update; host keeps clear
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            byte_idx_ff <= '0;
        end else if (end_conv) begin
            byte_idx_ff <= '0;
        end else if (byte_mode && rd_fall) begin
            // wraps after sixteen strobes, ascending channels
            byte_idx_ff <= byte_idx_ff + 4'h1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_byte_lane <= '0;
        end else if (byte_mode && rd_fall) begin
            o_byte_lane <= msb_sel ? byte_word[15:8] : byte_word[7:0];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_byte_lane_oe_n <= 1'b1;
        end else begin
            o_byte_lane_oe_n <= !(cs_low && byte_mode);
        end
    end

    // ------------------------------------------------------------
    // serial read-out
    // ------------------------------------------------------------
    logic [adcr_pkg::SER_POS_W-1:0] pos_ff;
    logic [adcr_pkg::SER_POS_W-1:0] nxt_pos;
    logic [adcr_pkg::CH_W-1:0] word_a;
    logic [adcr_pkg::CH_W-1:0] word_b;

    assign nxt_pos = sclk_rise ? pos_ff + 7'h1 : pos_ff;
    assign word_a = res_ff[nxt_pos[6:4]];
    assign word_b = res_ff[{!nxt_pos[6], nxt_pos[5:4]}];

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pos_ff <= '0;
        end else if (end_conv) begin
            pos_ff <= '0;
        end else if (ser_mode) begin
            pos_ff <= nxt_pos;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_serial_out_a <= 1'b0;
            o_serial_out_b <= 1'b0;
        end else if (ser_mode && (cs_fall || sclk_rise)) begin
            // msb first: bit index is the complement of the count
            o_serial_out_a <= word_a[~nxt_pos[3:0]];
            o_serial_out_b <= word_b[~nxt_pos[3:0]];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_serial_oe_n <= 1'b1;
        end else begin
            o_serial_oe_n <= !(cs_low && ser_mode);
        end
    end

    // ------------------------------------------------------------
    // first channel flag
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_first_channel_flag <= 1'b0;
        end else if (!cs_low) begin
            o_first_channel_flag <= 1'b0;
        end else if (cs_fall) begin
            // line B carries channel 5 in the same slot
            o_first_channel_flag <= ser_mode && (pos_ff[6:4] == 3'h0);
        end else if (byte_mode && rd_fall) begin
            o_first_channel_flag <= (byte_idx_ff < 4'h2);
        end else if (ser_mode && sclk_fall && pos_ff[3:0] == adcr_pkg::BIT_LAST) begin
            o_first_channel_flag <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_first_channel_flag_oe_n <= 1'b1;
        end else begin
            o_first_channel_flag_oe_n <= !(cs_low && (byte_mode || ser_mode));
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    logic [adcr_pkg::CNT_W-1:0] blen_ff;
    logic [adcr_pkg::CNT_W-1:0] blen_exp;

    assign blen_exp = adcr_pkg::CNT_W'(P_PASS_CYCLES) << shift_ff;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            blen_ff <= '0;
        end else if (start) begin
            blen_ff <= '0;
        end else if (o_busy) begin
            blen_ff <= blen_ff + 16'h1;
        end
    end

    sequence s_ser_open;
        ser_mode && cs_fall && !end_conv && pos_ff == 7'h0;
    endsequence

    sequence s_byte_first;
        byte_mode && rd_fall && !end_conv && byte_idx_ff == 4'h0;
    endsequence

    a_busy_start: assert property (start |=> o_busy ##1 o_busy)
        else $error("busy did not rise after both starts");
    a_busy_len: assert property (end_conv |-> blen_ff + 16'h1 == blen_exp)
        else $error("busy length does not match ratio");
    a_result_hold: assert property ($changed(res_ff[0]) |-> $past(end_conv))
        else $error("result changed outside busy fall");
    a_os_latch: assert property (end_conv && os_sync <= adcr_pkg::OS_MAX_SHIFT
        |=> shift_ff == $past(os_sync))
        else $error("oversampling select not captured");
    a_serial_float: assert property (!cs_low |=> o_serial_oe_n
        && o_first_channel_flag_oe_n)
        else $error("serial outputs driven while deselected");
    a_serial_msb: assert property (s_ser_open |=> o_serial_out_a == res_ff[0][15]
        && o_serial_out_b == res_ff[4][15] && o_first_channel_flag)
        else $error("serial frame did not open on channel msb");
    a_byte_first: assert property (s_byte_first |=> o_first_channel_flag
        && o_byte_lane == (hbf ? res_ff[0][15:8] : res_ff[0][7:0]))
        else $error("first byte or flag wrong");
    a_byte_third: assert property (byte_mode && rd_fall && !end_conv
        && byte_idx_ff == 4'h2 |=> !o_first_channel_flag)
        else $error("flag not dropped at third strobe");
    a_seq_restart: assert property (end_conv |=> byte_idx_ff == 4'h0
        && pos_ff == 7'h0)
        else $error("read sequence not restarted");
endmodule : adcr_readout

//--- dv/adcr_core_model.sv
/*
 * Converter core stand-in: answers each pass start with eight raw samples.
 * Assumes it shares i_clk with the read-out block and samples i_busy.
 */
`timescale 1ns/1ps
module adcr_core_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // pacing from the block; data base from the bench
    input wire logic i_pass_start,
    input wire logic i_busy,
    input wire logic [15:0] i_base,
    // raw samples
    output logic o_raw_valid,
    output logic [2:0] o_raw_chan,
    output logic [15:0] o_raw_data
);
    logic [3:0] cnt_ff;
    logic [6:0] pass_ff;
    logic [2:0] ch;
    assign ch = 3'(4'h8 - cnt_ff);
    // data steps by two per pass so an average differs from any one pass
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_ff <= 4'h0;
            pass_ff <= 7'h00;
            o_raw_valid <= 1'b0;
            o_raw_chan <= 3'h0;
            o_raw_data <= 16'h0000;
        end else begin
            o_raw_valid <= (cnt_ff != 4'h0);
            o_raw_chan <= ch;
            // idle data line keeps toggling so stale values never match
            o_raw_data <= (cnt_ff != 4'h0) ?
                i_base + {1'b0, ch, 12'h000} + {8'h00, pass_ff, 1'b0} : ~o_raw_data;
            if (i_pass_start) cnt_ff <= 4'h8;
            else if (cnt_ff != 4'h0) cnt_ff <= cnt_ff - 4'h1;
            if (!i_busy) pass_ff <= 7'h00;
            else if (cnt_ff == 4'h1) pass_ff <= pass_ff + 7'h01;
        end
    end
endmodule : adcr_core_model

//--- dv/adcr_readout_tb.sv
/*
 * Self-checking bench for the read-out block: conversions, byte and serial.
 * Assumes the core model answers pass starts; pins driven at i_clk rise.
 */
`timescale 1ns/1ps
module adcr_readout_tb;
    localparam int P = 40;
    typedef struct {string name; logic [1:0] kind; logic [15:0] val;} adcr_note_t;
    logic i_clk = 1'b0, i_rst_n = 1'b0, cs_n = 1'b1, rd_n = 1'b1, sclk = 1'b1;
    logic csta = 1'b0, cstb = 1'b0, isel = 1'b1, bsel = 1'b1, hbf = 1'b1;
    logic [2:0] os = 3'h0;
    logic [15:0] base = 16'h0000, got;
    logic [15:0] res [8];
    logic raw_valid, pass_start, o_busy, flag, flag_oe_n, lane_oe_n, sa, sb, ser_oe_n;
    logic [2:0] raw_chan;
    logic [15:0] raw_data;
    logic [7:0] lane;
    adcr_note_t exp_q [$], nt;
    int len_q [$];
    int errors = 0, num_checks = 0, seed = 25450, bcnt = 0;
    event sample_ev;
    always #4 i_clk = ~i_clk;
    adcr_readout #(.P_PASS_CYCLES(P)) dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cs_n(cs_n),
        .i_rd_n(rd_n), .i_sclk(sclk), .i_convert_start_a(csta), .i_convert_start_b(cstb),
        .i_interface_select(isel), .i_byte_select(bsel), .i_high_byte_first(hbf),
        .i_oversampling_ratio_select(os), .i_raw_valid(raw_valid), .i_raw_chan(raw_chan),
        .i_raw_data(raw_data), .o_pass_start(pass_start), .o_busy(o_busy),
        .o_first_channel_flag(flag), .o_first_channel_flag_oe_n(flag_oe_n),
        .o_byte_lane(lane), .o_byte_lane_oe_n(lane_oe_n), .o_serial_out_a(sa),
        .o_serial_out_b(sb), .o_serial_oe_n(ser_oe_n));
    adcr_core_model core (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_pass_start(pass_start),
        .i_busy(o_busy), .i_base(base), .o_raw_valid(raw_valid), .o_raw_chan(raw_chan),
        .o_raw_data(raw_data));
    // ----------------------------------------------------------------
    // checking
    // ----------------------------------------------------------------
    task give_verdict;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    task compare(string name, logic [15:0] exp, logic [15:0] seen);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : compare
    always @(sample_ev) begin
        #1;
        nt = exp_q.pop_front();
        case (nt.kind)
            2'h0: got = {6'h00, lane_oe_n, flag, lane};
            2'h1: got = {12'h000, ser_oe_n, flag, sa, sb};
            default: got = {13'h0000, lane_oe_n, ser_oe_n, flag_oe_n};
        endcase
        compare(nt.name, nt.val, got);
    end
    always @(posedge i_clk) begin
        if (o_busy === 1'b1) bcnt++;
        else if (bcnt > 0) begin
            if (len_q.size() == 0) compare("busy length", 16'hFFFF, 16'(bcnt));
            else compare("busy length", 16'(len_q.pop_front()), 16'(bcnt));
            bcnt = 0;
        end
    end
    initial begin
        repeat (100000) @(posedge i_clk);
        $display("mismatch run length expected end seen timeout");
        errors++;
        give_verdict();
    end
    // ----------------------------------------------------------------
    // stimulus helpers
    // ----------------------------------------------------------------
    task tick(int n);
        repeat (n) @(posedge i_clk);
    endtask : tick
    task note(string name, logic [1:0] kind, logic [15:0] v);
        exp_q.push_back('{name, kind, v});
        -> sample_ev;
    endtask : note
    task wait_busy(logic v);
        for (int i = 0; i < 2000 && o_busy !== v; i++) @(posedge i_clk);
        if (o_busy !== v) begin
            $display("mismatch busy wait expected %b seen %b", v, o_busy);
            errors++;
            give_verdict();
        end
    endtask : wait_busy
    task convert(logic [15:0] b, int len);
        base <= b;
        csta <= 1'b1;
        tick(5);
        cstb <= 1'b1; // both starts raised before busy
        tick(5);
        csta <= 1'b0;
        cstb <= 1'b0;
        wait_busy(1'b1);
        len_q.push_back(len);
    endtask : convert
    task set_res(logic [15:0] b, logic [15:0] add);
        for (int c = 0; c < 8; c++) res[c] = b + {1'b0, 3'(c), 12'h000} + add;
    endtask : set_res
    task rd_bytes(int n);
        logic up;
        for (int k = 0; k < n; k++) begin
            up = ((k % 2) == 0) == hbf;
            rd_n <= 1'b0;
            tick(5);
            note("byte lane", 2'h0, {7'h00, 1'(k < 2), up ? res[k/2][15:8] : res[k/2][7:0]});
            rd_n <= 1'b1;
            tick(5);
        end
    endtask : rd_bytes
    task ser(int first, int n);
        for (int p = first; p < first + n; p++) begin
            sclk <= 1'b0;
            tick(5);
            note("serial", 2'h1, {13'h0000, 1'(p < 15), res[p/16][15-p%16],
                 res[(p/16+4)%8][15-p%16]});
            sclk <= 1'b1;
            tick(5);
        end
    endtask : ser
    task deselect;
        cs_n <= 1'b1;
        tick(6);
        note("floated", 2'h2, 16'h0007);
    endtask : deselect
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        tick(10);
        i_rst_n <= 1'b1;
        tick(2);
        convert(16'($random(seed)) & 16'h0FF0, P);
        set_res(base, 16'h0000);
        os <= 3'h1;
        wait_busy(1'b0);
        rd_n <= 1'b0; // strobe while deselected
        tick(5);
        rd_n <= 1'b1;
        tick(5);
        cs_n <= 1'b0;
        tick(5);
        rd_bytes(16);
        deselect();
        $display("byte read done");
        convert(16'($random(seed)) & 16'h0FF0, 2 * P);
        os <= 3'h0;
        hbf <= 1'b0;
        cs_n <= 1'b0;
        tick(5);
        rd_bytes(2);
        deselect();
        wait_busy(1'b0);
        set_res(base, 16'h0001);
        cs_n <= 1'b0;
        tick(5);
        rd_bytes(16);
        deselect();
        $display("busy read done");
        bsel <= 1'b0;
        cs_n <= 1'b0;
        tick(5);
        ser(0, 16);
        deselect();
        for (int i = 0; i < 3; i++) begin
            sclk <= ~sclk;
            tick(5);
        end
        sclk <= 1'b1;
        tick(5);
        cs_n <= 1'b0;
        tick(5);
        ser(16, 112);
        deselect();
        $display("serial read done");
        isel <= 1'b0;
        cs_n <= 1'b0;
        tick(6);
        note("floated", 2'h2, 16'h0007);
        cs_n <= 1'b1;
        tick(6);
        $display("mode select done");
        give_verdict();
    end
endmodule : adcr_readout_tb
